//--- motion_io_pkg.sv
// Package with register map, field layout and reset values for the motion I/O configuration block.
package motion_io_pkg;

  localparam int unsigned NUM_IO = 8;
  localparam int unsigned NUM_AXES = 4;
  localparam int unsigned INH_FIRST = 4;

  // Register offsets (word addresses).
  localparam logic [3:0] ADDR_IO_CFG = 4'h0;
  localparam logic [3:0] ADDR_IO_OUT = 4'h1;
  localparam logic [3:0] ADDR_LIM_POL = 4'h2;
  localparam logic [3:0] ADDR_LOOP_MODE = 4'h3;
  localparam logic [3:0] ADDR_PORTC_DIR = 4'h4;
  localparam logic [3:0] ADDR_PORT_BC = 4'h5;
  localparam logic [3:0] ADDR_IO_STATUS = 4'h6;
  localparam logic [3:0] ADDR_SW_STATUS = 4'h7;
  localparam logic [3:0] ADDR_ERR = 4'h8;
  localparam logic [3:0] ADDR_ENC_SEL = 4'h9;
  localparam logic [3:0] ADDR_ENC_CNT = 4'hA;

  // Field positions.
  localparam int unsigned IO_POL_LSB = 8;
  localparam int unsigned IO_DIR_LSB = 0;
  localparam int unsigned HOME_POL_LSB = 8;
  localparam int unsigned LIM_POL_LSB = 0;
  localparam int unsigned LIM_POL_W = 12;
  localparam int unsigned PORTB_LSB = 0;
  localparam int unsigned PORTC_LSB = 8;

  // Loop mode codes.
  localparam logic [15:0] LOOP_OPEN = 16'h0000;
  localparam logic [15:0] LOOP_CLOSED = 16'hFFFF;

  // Reset values.
  localparam logic [7:0] IO_POL_RST = 8'hFF;
  localparam logic [7:0] IO_DIR_RST = 8'hFF;
  localparam logic [11:0] LIM_POL_RST = 12'hFFF;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic PORTC_DIR_RST = 1'b1;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] fwd;
    logic [3:0] rev;
    logic [3:0] home;
  } axis_sw_s;

endpackage

//--- sync2.sv
// Two-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else if (en)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

//--- enc_counter.sv
// Quadrature encoder counter for one axis, always counting regardless of loop mode.
`timescale 1ns/1ps
module enc_counter #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Synchronised encoder phases
  input wire logic phase_a,
  input wire logic phase_b,
  // Count
  output logic [WIDTH-1:0] count
);

  logic a_q;
  logic b_q;
  logic step;
  logic up;

  assign step = (phase_a ^ a_q) ^ (phase_b ^ b_q);
  assign up = phase_a ^ b_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      count <= '0;
    end
    else if (en)
    begin
      a_q <= phase_a;
      b_q <= phase_b;
      if (step)
      begin
        count <= up ? count + 1'b1 : count - 1'b1;
      end
    end
  end

endmodule

//--- motion_io_polarity_config.sv
// Motion I/O polarity, direction, loop mode and port C direction configuration.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Config word: high byte polarity, low byte direction.
// - Direction one means input, zero output.
// - Stepper ignores direction bits of lines 5-8.
// - Stepper keeps inhibit line settings on write.
// - Reset makes all I/O lines inverting inputs; stepper 5-8 outputs.
// - Active trigger input fires while level stays.
// - Limit word: home bits 11-8, limits 7-0.
// - Limit and home inputs reset inverting.
// - Inverting true when low, noninverting when high.
// - Loop mode zero open, minus one closed.
// - Encoder counter counts in open loop.
// - Closed loop uses encoder feedback for correction.
// - No closed-loop support rejects, flags error.
// - Port C direction zero output, one input.
// - Setting port C direction clears B and C.
// - Stepper reset: lines 1-4 inputs, 5-8 inhibit outputs.
module motion_io_polarity_config #(
  parameter bit STEPPER = 1'b1,
  parameter bit CLOSED_LOOP_OK = 1'b1,
  parameter int unsigned ENC_W = 16
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire motion_io_pkg::reg_req_s req,
  output logic [15:0] rdata,
  // Programmable I/O pins
  input wire logic [motion_io_pkg::NUM_IO-1:0] io_in,
  output logic [motion_io_pkg::NUM_IO-1:0] io_out,
  output logic [motion_io_pkg::NUM_IO-1:0] io_oe,
  // Inhibit output values from step configuration
  input wire logic [motion_io_pkg::NUM_AXES-1:0] inhibit_level,
  // Trigger enables and trigger outputs held while the input stays active
  input wire logic [motion_io_pkg::NUM_IO-1:0] trig_en,
  output logic [motion_io_pkg::NUM_IO-1:0] trig_fire,
  // Limit and home switches
  input wire motion_io_pkg::axis_sw_s sw_in,
  output motion_io_pkg::axis_sw_s sw_true,
  // Encoders
  input wire logic [motion_io_pkg::NUM_AXES-1:0] enc_a,
  input wire logic [motion_io_pkg::NUM_AXES-1:0] enc_b,
  // Loop mode per axis
  output logic [motion_io_pkg::NUM_AXES-1:0] closed_loop,
  // Auxiliary ports B and C
  input wire logic [7:0] portc_in,
  output logic [7:0] portb_out,
  output logic [7:0] portc_out,
  output logic portc_oe
);

  import motion_io_pkg::*;

  if (ENC_W < 1 || ENC_W > 16)
  begin : g_bad_enc_w
    $error("ENC_W must be 1 to 16");
  end

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [NUM_IO-1:0] io_in_s;
  axis_sw_s sw_raw_s;
  logic [NUM_AXES-1:0] enc_a_s;
  logic [NUM_AXES-1:0] enc_b_s;
  logic [7:0] portc_in_s;

  sync2 #(.WIDTH(NUM_IO + 12 + 2 * NUM_AXES + 8)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .en(clk_en),
    .d({io_in, sw_in, enc_a, enc_b, portc_in}),
    .q({io_in_s, sw_raw_s, enc_a_s, enc_b_s, portc_in_s})
  );

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  wire logic wr_io_cfg = clk_en && req.wr && req.addr == ADDR_IO_CFG;
  wire logic wr_io_out = clk_en && req.wr && req.addr == ADDR_IO_OUT;
  wire logic wr_lim = clk_en && req.wr && req.addr == ADDR_LIM_POL;
  wire logic wr_loop = clk_en && req.wr && req.addr == ADDR_LOOP_MODE;
  wire logic wr_portc_dir = clk_en && req.wr && req.addr == ADDR_PORTC_DIR;
  wire logic wr_port_bc = clk_en && req.wr && req.addr == ADDR_PORT_BC;
  wire logic wr_enc_sel = clk_en && req.wr && req.addr == ADDR_ENC_SEL;
  wire logic loop_valid = req.wdata == LOOP_OPEN || req.wdata == LOOP_CLOSED;
  // Lines 5-8 are inhibit lines on a stepper and hold their settings.
  wire logic [NUM_IO-1:0] keep_mask = STEPPER ? 8'hF0 : 8'h00;

  // ---------------------------------------------------------------
  // I/O port configuration
  // ---------------------------------------------------------------
  logic [NUM_IO-1:0] io_pol_q;
  logic [NUM_IO-1:0] io_dir_q;
  logic [NUM_IO-1:0] io_val_q;
  logic [NUM_IO-1:0] dir_eff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_pol_q <= IO_POL_RST;
      io_dir_q <= IO_DIR_RST;
    end
    else if (wr_io_cfg)
    begin
      io_pol_q <= (io_pol_q & keep_mask) | (req.wdata[IO_POL_LSB +: NUM_IO] & ~keep_mask);
      io_dir_q <= (io_dir_q & keep_mask) | (req.wdata[IO_DIR_LSB +: NUM_IO] & ~keep_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_val_q <= '0;
    end
    else if (wr_io_out)
    begin
      io_val_q <= (io_val_q & keep_mask) | (req.wdata[NUM_IO-1:0] & ~keep_mask);
    end
  end

  // Stepper inhibit lines are always outputs.
  assign dir_eff = STEPPER ? {4'h0, io_dir_q[INH_FIRST-1:0]} : io_dir_q;

  logic [NUM_IO-1:0] io_true;
  logic [NUM_IO-1:0] io_drive;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi++)
    begin : g_io
      // Inverting means true when the pin is low.
      assign io_true[gi] = io_in_s[gi] ^ io_pol_q[gi];
      if (gi >= INH_FIRST)
      begin : g_inh
        assign io_drive[gi] = STEPPER ? inhibit_level[gi - INH_FIRST] : (io_val_q[gi] ^ io_pol_q[gi]);
      end
      else
      begin : g_gp
        assign io_drive[gi] = io_val_q[gi] ^ io_pol_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_out <= '0;
      io_oe <= '0;
      trig_fire <= '0;
    end
    else if (clk_en)
    begin
      io_out <= io_drive;
      io_oe <= ~dir_eff;
      trig_fire <= trig_en & dir_eff & io_true;
    end
  end

  // ---------------------------------------------------------------
  // Limit and home switch polarity
  // ---------------------------------------------------------------
  logic [LIM_POL_W-1:0] lim_pol_q;
  logic [LIM_POL_W-1:0] sw_true_bits;
  axis_sw_s sw_true_d;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lim_pol_q <= LIM_POL_RST;
    end
    else if (wr_lim)
    begin
      lim_pol_q <= req.wdata[LIM_POL_W-1:0];
    end
  end

  // Bit 7 is axis 1 forward, bit 11 is axis 1 home.
  genvar ga;
  generate
    for (ga = 0; ga < NUM_AXES; ga++)
    begin : g_ax
      assign sw_true_bits[LIM_POL_LSB + 7 - 2 * ga] = sw_raw_s.fwd[ga] ^ lim_pol_q[LIM_POL_LSB + 7 - 2 * ga];
      assign sw_true_bits[LIM_POL_LSB + 6 - 2 * ga] = sw_raw_s.rev[ga] ^ lim_pol_q[LIM_POL_LSB + 6 - 2 * ga];
      assign sw_true_bits[HOME_POL_LSB + 3 - ga] = sw_raw_s.home[ga] ^ lim_pol_q[HOME_POL_LSB + 3 - ga];
      assign sw_true_d.fwd[ga] = sw_true_bits[LIM_POL_LSB + 7 - 2 * ga];
      assign sw_true_d.rev[ga] = sw_true_bits[LIM_POL_LSB + 6 - 2 * ga];
      assign sw_true_d.home[ga] = sw_true_bits[HOME_POL_LSB + 3 - ga];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_true <= '0;
    end
    else if (clk_en)
    begin
      sw_true <= sw_true_d;
    end
  end

  // ---------------------------------------------------------------
  // Loop mode and function error
  // ---------------------------------------------------------------
  logic func_err_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      closed_loop <= '0;
    end
    else if (wr_loop && CLOSED_LOOP_OK && loop_valid)
    begin
      closed_loop <= req.wdata == LOOP_CLOSED ? 4'hF : 4'h0;
    end
  end

  // A write of one clears; a rejected command in the same cycle still sets.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      func_err_q <= 1'b0;
    end
    else if (wr_loop && (!CLOSED_LOOP_OK || !loop_valid))
    begin
      func_err_q <= 1'b1;
    end
    else if (clk_en && req.wr && req.addr == ADDR_ERR && req.wdata[0])
    begin
      func_err_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Encoder counters
  // ---------------------------------------------------------------
  logic [ENC_W-1:0] enc_cnt [NUM_AXES];
  logic [1:0] enc_sel_q;

  genvar ge;
  generate
    for (ge = 0; ge < NUM_AXES; ge++)
    begin : g_enc
      enc_counter #(.WIDTH(ENC_W)) u_enc (
        .clk(clk),
        .rst_n(rst_n),
        .en(clk_en),
        .phase_a(enc_a_s[ge]),
        .phase_b(enc_b_s[ge]),
        .count(enc_cnt[ge])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enc_sel_q <= 2'h0;
    end
    else if (wr_enc_sel)
    begin
      enc_sel_q <= req.wdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Ports B and C
  // ---------------------------------------------------------------
  logic portc_dir_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portc_dir_q <= PORTC_DIR_RST;
      portc_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      portc_oe <= ~portc_dir_q;
      if (wr_portc_dir)
      begin
        portc_dir_q <= req.wdata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portb_out <= PORT_RST;
      portc_out <= PORT_RST;
    end
    else if (wr_portc_dir)
    begin
      portb_out <= PORT_RST;
      portc_out <= PORT_RST;
    end
    else if (wr_port_bc)
    begin
      portb_out <= req.wdata[PORTB_LSB +: 8];
      if (!portc_dir_q)
      begin
        portc_out <= req.wdata[PORTC_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = 16'h0000;
    case (req.addr)
      ADDR_IO_CFG: rdata_d = {io_pol_q, io_dir_q};
      ADDR_IO_OUT: rdata_d = {8'h00, io_val_q};
      ADDR_LIM_POL: rdata_d = {4'h0, lim_pol_q};
      ADDR_LOOP_MODE: rdata_d = {12'h000, closed_loop};
      ADDR_PORTC_DIR: rdata_d = {15'h0000, portc_dir_q};
      ADDR_PORT_BC: rdata_d = {portc_dir_q ? portc_in_s : portc_out, portb_out};
      ADDR_IO_STATUS: rdata_d = {8'h00, io_true};
      ADDR_SW_STATUS: rdata_d = {4'h0, sw_true_bits};
      ADDR_ERR: rdata_d = {15'h0000, func_err_q};
      ADDR_ENC_SEL: rdata_d = {14'h0000, enc_sel_q};
      ADDR_ENC_CNT: rdata_d = 16'(enc_cnt[enc_sel_q]);
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 16'h0000;
    end
    else if (clk_en)
    begin
      rdata <= req.rd ? rdata_d : 16'h0000;
    end
  end

endmodule

//--- motion_io_polarity_config_assertions.sv
// Checker with concurrent assertions for the motion I/O configuration block.
`timescale 1ns/1ps
module motion_io_checker
  import motion_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire motion_io_pkg::reg_req_s req,
  // Programmable I/O
  input wire logic [7:0] io_in,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  input wire logic [3:0] inhibit_level,
  input wire logic [7:0] trig_en,
  input wire logic [7:0] trig_fire,
  // Switches and loop mode
  input wire motion_io_pkg::axis_sw_s sw_in,
  input wire motion_io_pkg::axis_sw_s sw_true,
  input wire logic [3:0] closed_loop,
  // Ports B and C
  input wire logic [7:0] portb_out,
  input wire logic [7:0] portc_out,
  input wire logic portc_oe
);
  // ----------------------------------------
  // Shadow of the configuration words
  // ----------------------------------------
  logic [15:0] cfg_q;
  logic [11:0] lim_q;
  logic [11:0] sw_exp;
  logic [3:0] trig_exp;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= {IO_POL_RST, IO_DIR_RST};
    else if (clk_en && req.wr && req.addr == ADDR_IO_CFG)
      cfg_q <= {cfg_q[15:12], req.wdata[11:8], cfg_q[7:4], req.wdata[3:0]};
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lim_q <= LIM_POL_RST;
    else if (clk_en && req.wr && req.addr == ADDR_LIM_POL)
      lim_q <= req.wdata[11:0];
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      sw_exp[8+i] = sw_in.fwd[i] ^ lim_q[7-2*i];
      sw_exp[4+i] = sw_in.rev[i] ^ lim_q[6-2*i];
      sw_exp[i] = sw_in.home[i] ^ lim_q[11-i];
    end
  end
  assign trig_exp = trig_en[3:0] & cfg_q[3:0] & (io_in[3:0] ^ cfg_q[11:8]);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  inhibit_oe_a: assert property (rst_n && clk_en |=> io_oe[7:4] == 4'hf)
    else $error("inhibit lines not driven");
  inhibit_out_a: assert property (rst_n && clk_en |=> io_out[7:4] == $past(inhibit_level))
    else $error("inhibit level not passed to pins");
  line_dir_a: assert property ($stable(cfg_q)[*2] |-> io_oe[3:0] == ~cfg_q[3:0])
    else $error("line direction mismatch");
  trig_level_a: assert property (($stable(io_in) && $stable(trig_en) && $stable(cfg_q))[*5]
    |-> trig_fire[3:0] == trig_exp)
    else $error("trigger level mismatch");
  switch_true_a: assert property (($stable(sw_in) && $stable(lim_q))[*5] |-> sw_true == sw_exp)
    else $error("switch true state mismatch");
  port_clear_a: assert property (clk_en && req.wr && req.addr == ADDR_PORTC_DIR
    |-> ##1 (portb_out == 8'h00 && portc_out == 8'h00))
    else $error("ports not cleared");
  portc_dir_a: assert property (clk_en && req.wr && req.addr == ADDR_PORTC_DIR
    |-> ##2 portc_oe == !$past(req.wdata[0], 2))
    else $error("port C direction mismatch");
  loop_set_a: assert property (clk_en && req.wr && req.addr == ADDR_LOOP_MODE
    && (req.wdata == LOOP_OPEN || req.wdata == LOOP_CLOSED)
    |-> ##1 closed_loop == {4{$past(req.wdata[0])}})
    else $error("loop mode mismatch");
endmodule
bind motion_io_polarity_config motion_io_checker i_motion_io_checker (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req(req), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .inhibit_level(inhibit_level), .trig_en(trig_en), .trig_fire(trig_fire),
  .sw_in(sw_in), .sw_true(sw_true), .closed_loop(closed_loop), .portb_out(portb_out),
  .portc_out(portc_out), .portc_oe(portc_oe)
);

//--- motion_io_polarity_config_tb.sv
// Self-checking testbench for the motion I/O configuration block.
`timescale 1ns/1ps
module motion_io_polarity_config_tb;
  import motion_io_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  reg_req_s req = '0;
  logic [15:0] rdata;
  logic [7:0] io_in = 8'h00;
  logic [7:0] io_out;
  logic [7:0] io_oe;
  logic [3:0] inhibit_level = 4'h0;
  logic [7:0] trig_en = 8'h00;
  logic [7:0] trig_fire;
  axis_sw_s sw_in = '0;
  axis_sw_s sw_true;
  logic [3:0] enc_a = 4'h0;
  logic [3:0] enc_b = 4'h0;
  logic [3:0] closed_loop;
  logic [7:0] portc_in = 8'h00;
  logic [7:0] portb_out;
  logic [7:0] portc_out;
  logic portc_oe;
  logic [15:0] d;
  logic [15:0] c0;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  motion_io_polarity_config i_motion_io_polarity_config (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rdata(rdata), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .inhibit_level(inhibit_level), .trig_en(trig_en),
    .trig_fire(trig_fire), .sw_in(sw_in), .sw_true(sw_true), .enc_a(enc_a), .enc_b(enc_b),
    .closed_loop(closed_loop), .portc_in(portc_in), .portb_out(portb_out),
    .portc_out(portc_out), .portc_oe(portc_oe)
  );
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    chk("oe", io_oe, 16'h00f0);
    rd(ADDR_IO_CFG);
    chk("cfg", d & 16'h0f0f, 16'h0f0f);
    rd(ADDR_LIM_POL);
    chk("lim", d, 16'h0fff);
    rd(ADDR_LOOP_MODE);
    chk("loop", d, 16'h0000);
    rd(4'hf);
    chk("unmapped", d, 16'h0000);
    $display("test reset done");
    wr(ADDR_IO_CFG, 16'h0a05);
    rd(ADDR_IO_CFG);
    chk("cfg", d, 16'hfaf5);
    @(posedge clk);
    inhibit_level <= 4'h9;
    wr(ADDR_IO_OUT, 16'h00f5);
    wt(3);
    chk("oe", io_oe, 16'h00fa);
    chk("inh", io_out[7:4], 16'h0009);
    chk("out", io_out[3:0] & 4'ha, 16'h000a);
    wr(ADDR_IO_CFG, 16'h0a0f);
    @(posedge clk);
    trig_en <= 8'h0f;
    wt(5);
    chk("fire", trig_fire[3:0], 16'h000a);
    rd(ADDR_IO_STATUS);
    chk("stat", d[3:0], 16'h000a);
    @(posedge clk);
    io_in <= 8'h0f;
    wt(5);
    chk("fire", trig_fire[3:0], 16'h0005);
    wt(10);
    chk("fire", trig_fire[3:0], 16'h0005);
    $display("test io port done");
    wr(ADDR_LIM_POL, 16'hf5a3);
    rd(ADDR_LIM_POL);
    chk("lim", d, 16'h05a3);
    wt(5);
    chk("sw", sw_true, 16'h0b8a);
    rd(ADDR_SW_STATUS);
    chk("swst", d, 16'h05a3);
    @(posedge clk);
    sw_in <= 12'hfff;
    wt(5);
    chk("sw", sw_true, 16'h0475);
    $display("test switches done");
    wr(ADDR_LOOP_MODE, LOOP_CLOSED);
    wt(2);
    chk("cl", closed_loop, 16'h000f);
    wr(ADDR_LOOP_MODE, 16'h1234);
    rd(ADDR_ERR);
    chk("err", d & 16'h0001, 16'h0001);
    rd(ADDR_LOOP_MODE);
    chk("loop", d, 16'h000f);
    wr(ADDR_ERR, 16'h0001);
    rd(ADDR_ERR);
    chk("err", d & 16'h0001, 16'h0000);
    wr(ADDR_LOOP_MODE, LOOP_OPEN);
    wt(2);
    chk("cl", closed_loop, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(ADDR_LOOP_MODE, LOOP_CLOSED);
    clk_en <= 1'b1;
    wt(2);
    chk("frz", closed_loop, 16'h0000);
    wr(ADDR_ENC_SEL, 16'h0000);
    rd(ADDR_ENC_CNT);
    c0 = d;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      enc_a[0] <= (i < 2);
      enc_b[0] <= (i == 1 || i == 2);
      wt(4);
    end
    rd(ADDR_ENC_CNT);
    chk("enc", {15'h0000, (d - c0 == 16'h0004) || (d - c0 == 16'hfffc)}, 16'h0001);
    $display("test loop mode done");
    wr(ADDR_PORTC_DIR, 16'h0000);
    wt(2);
    chk("coe", portc_oe, 16'h0001);
    wr(ADDR_PORT_BC, 16'h5aa5);
    wt(2);
    chk("pb", portb_out, 16'h00a5);
    chk("pc", portc_out, 16'h005a);
    wr(ADDR_PORTC_DIR, 16'h0001);
    wt(2);
    chk("pb", portb_out, 16'h0000);
    chk("pc", portc_out, 16'h0000);
    chk("coe", portc_oe, 16'h0000);
    @(posedge clk);
    portc_in <= 8'h3c;
    wr(ADDR_PORT_BC, 16'h1234);
    wt(4);
    chk("pb", portb_out, 16'h0034);
    rd(ADDR_PORT_BC);
    chk("pcin", d, 16'h3c34);
    $display("test ports done");
    end_sim();
  end
endmodule
